/* File: logic/aspb_top.sv */
// Serial port core: AXI4-Lite registers, transmitter, receiver, baud timers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Data write loads transmitter; read returns receive buffer
// - Completed byte held in separate receive buffer
// - Done flags cleared only by software
// - Interrupt when enabled and either flag set
// - Transmit clock from auto-reload counter overflows
// - Hidden receive counter shares reload byte
// - Both overflow streams divided by two
// - Start detect forces receive counter reload
// - One mode bit selects 8 or 9-bit frames
// - 8-bit frame: start, eight data LSB first, stop
// - 8-bit receive stores data and stop bit
// - Data write starts send; flag at stop start
// - Receive only while receive enable set
// - 8-bit accept needs flag clear, filtered stop one
// - Overrun keeps first byte, drops later ones
// - 9-bit frame adds ninth bit from control
// - 9-bit receive stores ninth bit, ignores stop
// - 9-bit accept needs flag clear, filtered ninth one
module aspb_top
  import aspb_pkg::*;
#(
  parameter int unsigned ADDR_W = AXI_ADDR_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  input  wire logic              serial_in_pin,
  output logic                   serial_out_pin,
  output logic                   irq
);

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} aspb_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} aspb_rx_e;

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------
  logic              aw_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              w_held_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              do_wr;
  logic [3:0]        wr_word;
  logic [3:0]        rd_word;
  logic              wr_ctrl;
  logic              wr_data;
  logic              wr_tmr_lo;
  logic              wr_tmr_hi;
  logic              rd_take;

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Address and data may arrive in either order; the write waits for both
  assign do_wr     = aw_held_q && w_held_q && !bvalid_q;
  assign wr_word   = {awaddr_q[3:2], 2'b00};
  assign rd_word   = {s_axi_araddr[3:2], 2'b00};
  assign wr_ctrl   = do_wr && (wr_word == OFF_CTRL) && wstrb_q[0];
  assign wr_data   = do_wr && (wr_word == OFF_DATA) && wstrb_q[0];
  assign wr_tmr_lo = do_wr && (wr_word == OFF_TIMER) && wstrb_q[0];
  assign wr_tmr_hi = do_wr && (wr_word == OFF_TIMER) && wstrb_q[1];
  assign rd_take   = s_axi_arvalid && !rvalid_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_word == OFF_CTRL || wr_word == OFF_DATA || wr_word == OFF_TIMER)
                  ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control and timer registers
  // ---------------------------------------------------------------
  logic       mode_q;
  logic       mce_q;
  logic       ren_q;
  logic       tb8_q;
  logic       rb8_q;
  logic       ti_q;
  logic       ri_q;
  logic       run_q;
  logic       irq_en_q;
  logic [7:0] reload_q;
  logic [7:0] rx_buf_q;
  logic       ti_set;
  logic       rx_load;
  logic       rx_flag_bit;
  logic [7:0] baud_counter_low;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      mce_q  <= 1'b0;
      ren_q  <= 1'b0;
      tb8_q  <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q <= wdata_q[CTRL_MODE_BIT];
      mce_q  <= wdata_q[CTRL_MCE_BIT];
      ren_q  <= wdata_q[CTRL_REN_BIT];
      tb8_q  <= wdata_q[CTRL_TB8_BIT];
    end
  end

  // Hardware sets win over a software write in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ti_q <= 1'b0;
    end else if (ti_set) begin
      ti_q <= 1'b1;
    end else if (wr_ctrl) begin
      ti_q <= wdata_q[CTRL_TI_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ri_q  <= 1'b0;
      rb8_q <= 1'b0;
    end else if (rx_load) begin
      ri_q  <= 1'b1;
      rb8_q <= rx_flag_bit;
    end else if (wr_ctrl) begin
      ri_q  <= wdata_q[CTRL_RI_BIT];
      rb8_q <= wdata_q[CTRL_RB8_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_q    <= 1'b0;
      irq_en_q <= 1'b0;
    end else if (wr_tmr_lo) begin
      run_q    <= wdata_q[TMR_RUN_BIT];
      irq_en_q <= wdata_q[TMR_IRQEN_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reload_q <= RELOAD_RST;
    end else if (wr_tmr_hi) begin
      reload_q <= wdata_q[TMR_RELOAD_LSB +: 8];
    end
  end

  assign irq = irq_en_q && (ti_q || ri_q);

  // Reads have no side effects; the transmit register is never visible
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      unique case (rd_word)
        OFF_CTRL:  rdata_q <= {24'h000000, mode_q, 1'b1, mce_q, ren_q,
                               tb8_q, rb8_q, ti_q, ri_q};
        OFF_DATA:  rdata_q <= {24'h000000, rx_buf_q};
        OFF_TIMER: rdata_q <= {8'h00, baud_counter_low, reload_q,
                               6'h00, irq_en_q, run_q};
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Baud timers
  // ---------------------------------------------------------------
  logic       tx_tick;
  logic       rx_tick;
  logic       rx_start;
  logic [7:0] rx_count;

  aspb_baud_timer #(.CNT_W(8)) u_tx_timer (
    .core_clk     (core_clk),
    .rst          (rst),
    .run          (run_q),
    .force_reload (1'b0),
    .reload       (reload_q),
    .count        (baud_counter_low),
    .ovf          (),
    .tick         (tx_tick)
  );

  // Private copy for the receiver so its phase follows the start edge
  aspb_baud_timer #(.CNT_W(8)) u_rx_timer (
    .core_clk     (core_clk),
    .rst          (rst),
    .run          (run_q),
    .force_reload (rx_start),
    .reload       (reload_q),
    .count        (rx_count),
    .ovf          (),
    .tick         (rx_tick)
  );

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  aspb_tx_e   tx_st_q;
  logic [7:0] tx_hold_q;
  logic [7:0] tx_shift_q;
  logic       tx_pend_q;
  logic [2:0] tx_bit_q;
  logic       tx_launch;

  assign tx_launch = (tx_st_q == TX_IDLE) && tx_pend_q && tx_tick;
  assign ti_set    = tx_tick && (((tx_st_q == TX_DATA) && (tx_bit_q == BIT_LAST) && !mode_q)
                     || (tx_st_q == TX_NINTH));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_hold_q <= DATA_RST;
      tx_pend_q <= 1'b0;
    end else if (wr_data) begin
      tx_hold_q <= wdata_q[7:0];
      tx_pend_q <= 1'b1;
    end else if (tx_launch) begin
      tx_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q        <= TX_IDLE;
      tx_shift_q     <= DATA_RST;
      tx_bit_q       <= BIT_FIRST;
      serial_out_pin <= LINE_IDLE;
    end else if (tx_tick) begin
      unique case (tx_st_q)
        TX_IDLE: if (tx_pend_q) begin
          tx_st_q        <= TX_START;
          tx_shift_q     <= tx_hold_q;
          serial_out_pin <= LINE_START;
        end
        TX_START: begin
          tx_st_q        <= TX_DATA;
          tx_bit_q       <= BIT_FIRST;
          serial_out_pin <= tx_shift_q[0];
        end
        TX_DATA: if (tx_bit_q == BIT_LAST) begin
          tx_st_q        <= mode_q ? TX_NINTH : TX_STOP;
          serial_out_pin <= mode_q ? tb8_q : LINE_STOP;
        end else begin
          tx_shift_q     <= {1'b0, tx_shift_q[7:1]};
          tx_bit_q       <= tx_bit_q + 1'b1;
          serial_out_pin <= tx_shift_q[1];
        end
        TX_NINTH: begin
          tx_st_q        <= TX_STOP;
          serial_out_pin <= LINE_STOP;
        end
        TX_STOP: begin
          tx_st_q        <= TX_IDLE;
          serial_out_pin <= LINE_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  aspb_rx_e   rx_st_q;
  logic       rx_s1_q;
  logic       rx_s2_q;
  logic       rx_prev_q;
  logic [7:0] rx_shift_q;
  logic [2:0] rx_bit_q;
  logic       rx_ninth_q;
  logic       rx_stop_tick;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_s1_q   <= LINE_IDLE;
      rx_s2_q   <= LINE_IDLE;
      rx_prev_q <= LINE_IDLE;
    end else begin
      rx_s1_q   <= serial_in_pin;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  assign rx_start     = (rx_st_q == RX_IDLE) && ren_q && rx_prev_q && !rx_s2_q;
  assign rx_stop_tick = (rx_st_q == RX_STOP) && rx_tick;
  // Stop bit acts as the filter bit in 8-bit mode, ninth bit in 9-bit mode
  assign rx_flag_bit  = mode_q ? rx_ninth_q : rx_s2_q;
  // A full buffer drops the new frame, so the first byte survives overrun
  assign rx_load      = rx_stop_tick && !ri_q && (!mce_q || rx_flag_bit);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_buf_q <= DATA_RST;
    end else if (rx_load) begin
      rx_buf_q <= rx_shift_q;
    end
  end

  // Clearing receive enable abandons a frame in progress
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q    <= RX_IDLE;
      rx_shift_q <= DATA_RST;
      rx_bit_q   <= BIT_FIRST;
      rx_ninth_q <= 1'b0;
    end else if (!ren_q) begin
      rx_st_q <= RX_IDLE;
    end else if (rx_start) begin
      rx_st_q <= RX_START;
    end else if (rx_tick) begin
      unique case (rx_st_q)
        RX_IDLE: rx_st_q <= RX_IDLE;
        RX_START: begin
          rx_st_q  <= rx_s2_q ? RX_IDLE : RX_DATA;
          rx_bit_q <= BIT_FIRST;
        end
        RX_DATA: begin
          rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]};
          rx_bit_q   <= rx_bit_q + 1'b1;
          if (rx_bit_q == BIT_LAST) begin
            rx_st_q <= mode_q ? RX_NINTH : RX_STOP;
          end
        end
        RX_NINTH: begin
          rx_ninth_q <= rx_s2_q;
          rx_st_q    <= RX_STOP;
        end
        RX_STOP: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_tx_launch;
    (tx_st_q == TX_IDLE) && tx_pend_q && tx_tick;
  endsequence

  sequence s_rx_stop_sample;
    (rx_st_q == RX_STOP) && rx_tick;
  endsequence

  AST_TX_START_LOW: assert property (
    s_tx_launch |=> (tx_st_q == TX_START) && (serial_out_pin == LINE_START))
    else $error("start bit not driven low");

  AST_TX_IDLE_HIGH: assert property (
    (tx_st_q == TX_IDLE) ##1 (tx_st_q == TX_IDLE) |-> serial_out_pin == LINE_IDLE)
    else $error("idle line not high");

  AST_TI_AT_STOP: assert property (
    (tx_st_q != TX_STOP) ##1 (tx_st_q == TX_STOP) |-> ti_q && serial_out_pin == LINE_STOP)
    else $error("transmit flag not set at stop bit");

  AST_TI_HOLD: assert property (
    ti_q && !wr_ctrl |=> ti_q)
    else $error("transmit flag cleared without software");

  AST_RI_HOLD: assert property (
    ri_q && !wr_ctrl |=> ri_q)
    else $error("receive flag cleared without software");

  AST_IRQ_RISE: assert property (
    $rose(ri_q || ti_q) && irq_en_q |-> irq)
    else $error("interrupt missing on flag set");

  AST_RX_DISABLED: assert property (
    !ren_q |=> rx_st_q == RX_IDLE)
    else $error("receiver active while disabled");

  AST_RX_OVERRUN: assert property (
    ri_q ##1 ri_q |-> $stable(rx_buf_q))
    else $error("receive buffer overwritten on overrun");

  AST_RB8_STOP: assert property (
    s_rx_stop_sample ##0 (rx_load && !mode_q) |=> rb8_q == $past(rx_s2_q) && ri_q)
    else $error("stop bit not stored");

  AST_RB8_NINTH: assert property (
    s_rx_stop_sample ##0 (rx_load && mode_q) |=> rb8_q == $past(rx_ninth_q))
    else $error("ninth bit not stored");

  AST_FILTER_8: assert property (
    s_rx_stop_sample ##0 (!mode_q && (ri_q || (mce_q && !rx_s2_q))) |-> !rx_load)
    else $error("8-bit frame accepted against filter");

  AST_FILTER_9: assert property (
    s_rx_stop_sample ##0 (mode_q && (ri_q || (mce_q && !rx_ninth_q))) |-> !rx_load)
    else $error("9-bit frame accepted against filter");

  AST_BUF_LOAD: assert property (
    rx_load |=> rx_buf_q == $past(rx_shift_q))
    else $error("receive buffer not loaded");

  AST_DATA_READ: assert property (
    rd_take && (rd_word == OFF_DATA) |=> s_axi_rdata[7:0] == $past(rx_buf_q))
    else $error("data read did not return receive buffer");

  AST_RX_RELOAD: assert property (
    rx_start |=> rx_count == $past(reload_q))
    else $error("receive counter not reloaded on start");

endmodule // aspb_top

`default_nettype wire

/* File: logic/aspb_pkg.sv */
// Shared constants for the asynchronous serial port with baud timer
package aspb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam int unsigned AXI_ADDR_W = 4;
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_DATA   = 4'h4;
  localparam logic [3:0]  OFF_TIMER  = 4'h8;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_MODE_BIT = 7;
  localparam int unsigned CTRL_ONE_BIT  = 6;
  localparam int unsigned CTRL_MCE_BIT  = 5;
  localparam int unsigned CTRL_REN_BIT  = 4;
  localparam int unsigned CTRL_TB8_BIT  = 3;
  localparam int unsigned CTRL_RB8_BIT  = 2;
  localparam int unsigned CTRL_TI_BIT   = 1;
  localparam int unsigned CTRL_RI_BIT   = 0;

  // ---------------------------------------------------------------
  // Timer register fields
  // ---------------------------------------------------------------
  localparam int unsigned TMR_RUN_BIT    = 0;
  localparam int unsigned TMR_IRQEN_BIT  = 1;
  localparam int unsigned TMR_RELOAD_LSB = 8;
  localparam int unsigned TMR_COUNT_LSB  = 16;

  // ---------------------------------------------------------------
  // Reset values and frame constants
  // ---------------------------------------------------------------
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [2:0] BIT_FIRST  = 3'h0;
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic       LINE_IDLE  = 1'b1;
  localparam logic       LINE_START = 1'b0;
  localparam logic       LINE_STOP  = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: logic/aspb_baud_timer.sv */
// Eight-bit auto-reload baud counter with divide-by-two bit tick
`timescale 1ns/1ps
`default_nettype none

module aspb_baud_timer
  import aspb_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             run,
  input  wire logic             force_reload,
  input  wire logic [CNT_W-1:0] reload,
  output logic      [CNT_W-1:0] count,
  output logic                  ovf,
  output logic                  tick
);

  logic [CNT_W-1:0] cnt_q;
  logic             half_q;

  assign count = cnt_q;
  assign ovf   = run && !force_reload && (cnt_q == {CNT_W{1'b1}});
  // A forced reload presets the phase so the first overflow is a tick
  assign tick  = ovf && half_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_W'(CNT_RST);
    end else if (force_reload || ovf) begin
      cnt_q <= reload;
    end else if (run) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      half_q <= 1'b0;
    end else if (force_reload) begin
      half_q <= 1'b1;
    end else if (ovf) begin
      half_q <= ~half_q;
    end
  end

  AST_OVF_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
    ovf |=> count == $past(reload))
    else $error("counter did not reload after overflow");

  AST_FORCE_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
    force_reload |=> count == $past(reload) && half_q)
    else $error("forced reload did not preset counter and phase");

  AST_TICK_HALF: assert property (@(posedge core_clk) disable iff (rst)
    ovf |=> half_q != $past(half_q))
    else $error("tick rate not half of overflow rate");

endmodule // aspb_baud_timer

`default_nettype wire

/* File: sim/aspb_remote.sv */
// Remote serial transceiver model facing the port's line pins
`timescale 1ns/1ps
`default_nettype none

module aspb_remote #(
  parameter int unsigned BIT_CYC = 8
) (
  input  wire logic core_clk,
  input  wire logic line_in,
  output var  logic line_out
);
  initial line_out = 1'b1;

  // ---------------------------------------------------------------
  // Frame sender, line held high between frames
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] d, input logic nine, input logic ninth,
                      input logic stop);
    logic [10:0] f;
    f = nine ? {stop, ninth, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge core_clk);
      line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    line_out <= 1'b1;
    repeat (BIT_CYC) @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // Frame catcher, samples mid-bit after the falling edge
  // ---------------------------------------------------------------
  task automatic get(input logic nine, output logic [10:0] f, output logic ok);
    int n;
    f = '1;
    n = 0;
    ok = 1'b0;
    while (n < 40 * BIT_CYC && !ok) begin
      @(posedge core_clk);
      ok = !line_in;
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      f[i] = line_in;
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask
endmodule // aspb_remote

`default_nettype wire

/* File: sim/test_async_serial_port_with_baud_timer.sv */
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none

module test_async_serial_port_with_baud_timer;
  import aspb_pkg::*;
  logic core_clk, rst, irq, tx_line, rx_line;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, bresp_seen;
  logic [10:0] frm;
  logic ok;
  int mismatches = 0;
  int n_compared = 0;

  aspb_top i_dut (.core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .serial_in_pin(rx_line),
    .serial_out_pin(tx_line), .irq(irq));
  // Reload 8'hfc gives overflow every 4 cycles, so one bit is 8 cycles
  aspb_remote #(.BIT_CYC(8)) i_remote (.core_clk(core_clk), .line_in(tx_line),
    .line_out(rx_line));

  always #10 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // AXI4-Lite master
  // ---------------------------------------------------------------
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    bresp_seen = s_axi_bresp;
    if (!s_axi_bvalid) begin
      chk(32'h0, 32'h1);
      tally_and_finish;
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    if (!s_axi_rvalid) begin
      chk(32'h0, 32'h1);
      tally_and_finish;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(OFF_CTRL, 32'h40, RESP_OKAY);
    rd(OFF_DATA, 32'h0, RESP_OKAY);
    rd(4'hc, 32'h0, RESP_SLVERR);
    axw(4'hc, 32'hffffffff);
    chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
    s_axi_wstrb <= 4'h2;
    axw(OFF_CTRL, 32'h10);
    s_axi_wstrb <= 4'hf;
    rd(OFF_CTRL, 32'h40, RESP_OKAY);
    axw(OFF_TIMER, 32'h0000fc02);
    chk({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
    rd(OFF_TIMER, 32'h0000fc02, RESP_OKAY);
    $display("test reset done");
  endtask

  task automatic t_tx8;
    axw(OFF_TIMER, 32'h0000fc03);
    axw(OFF_CTRL, 32'h0);
    fork
      i_remote.get(1'b0, frm, ok);
      axw(OFF_DATA, 32'ha5);
    join
    chk({21'h0, frm}, {21'h0, 2'b11, 8'ha5, 1'b0});
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_CTRL, 32'h42, RESP_OKAY);
    repeat (50) @(posedge core_clk);
    rd(OFF_CTRL, 32'h42, RESP_OKAY);
    rd(OFF_DATA, 32'h0, RESP_OKAY);
    axw(OFF_CTRL, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test tx8 done");
  endtask

  task automatic t_rx8;
    axw(OFF_CTRL, 32'h10);
    i_remote.send(8'h3c, 1'b0, 1'b0, 1'b1);
    rd(OFF_DATA, 32'h3c, RESP_OKAY);
    rd(OFF_CTRL, 32'h55, RESP_OKAY);
    i_remote.send(8'hc3, 1'b0, 1'b0, 1'b1);
    rd(OFF_DATA, 32'h3c, RESP_OKAY);
    axw(OFF_CTRL, 32'h30);
    i_remote.send(8'h77, 1'b0, 1'b0, 1'b0);
    rd(OFF_CTRL, 32'h70, RESP_OKAY);
    axw(OFF_CTRL, 32'h0);
    i_remote.send(8'h99, 1'b0, 1'b0, 1'b1);
    rd(OFF_CTRL, 32'h40, RESP_OKAY);
    $display("test rx8 done");
  endtask

  task automatic t_nine;
    axw(OFF_CTRL, 32'h88);
    fork
      i_remote.get(1'b1, frm, ok);
      axw(OFF_DATA, 32'h5a);
    join
    chk({21'h0, frm}, {21'h0, 2'b11, 8'h5a, 1'b0});
    rd(OFF_CTRL, 32'hca, RESP_OKAY);
    axw(OFF_CTRL, 32'hb0);
    i_remote.send(8'h11, 1'b1, 1'b0, 1'b1);
    rd(OFF_CTRL, 32'hf0, RESP_OKAY);
    i_remote.send(8'h22, 1'b1, 1'b1, 1'b0);
    rd(OFF_DATA, 32'h22, RESP_OKAY);
    rd(OFF_CTRL, 32'hf5, RESP_OKAY);
    $display("test nine done");
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_tx8;
    t_rx8;
    t_nine;
    tally_and_finish;
  end
endmodule // test_async_serial_port_with_baud_timer

`default_nettype wire
